/* core/sensor_supervisory_sequencer.sv */
// Supervisory sequencer: supply qualification, reset, self-test and output-invalid flag.
// Assumes supply and overload comparators and pins arrive asynchronously as levels.

module sensor_supervisory_sequencer #(
	parameter int unsigned STARTUP_TICKS = seq_pkg::STARTUP_TICKS,
	parameter int unsigned ST_HALF_TICKS = seq_pkg::ST_HALF_TICKS
) (
	// Clock and reset
	input  wire logic                      core_clk_in,
	input  wire logic                      reset_in,
	// Supply and overload comparators
	input  wire logic                      supply_above_trip_in,
	input  wire logic                      overload_in,
	// Host pins
	input  wire logic                      ext_reset_n_in,
	input  wire logic                      self_test_request_in,
	// Readout sample
	input  wire logic [seq_pkg::OUT_W-1:0] accel_code_in,
	// Outputs
	output logic                           supply_good_out,
	output logic                           output_invalid_out,
	output logic [seq_pkg::OUT_W-1:0]      accel_out_pos_out,
	output logic [seq_pkg::OUT_W-1:0]      accel_out_neg_out,
	output logic [seq_pkg::OUT_W-1:0]      mid_reference_out
);
	typedef enum logic [3:0] {
		ST_OFF     = 4'b0001,
		ST_HOLD    = 4'b0010,
		ST_STARTUP = 4'b0100,
		ST_RUN     = 4'b1000
	} seq_state_t;

	// Two-flop synchroniser per asynchronous level
	localparam logic [3:0] SYNC_RESET = 4'h2;
	wire  [3:0] raw_in = {supply_above_trip_in, overload_in, ext_reset_n_in, self_test_request_in};
	wire  [3:0] synced;

	for (genvar g = 0; g < 4; g++) begin : g_sync
		logic meta_q;
		logic stable_q;

		always_ff @(posedge core_clk_in or posedge reset_in) begin
			if (reset_in) begin
				meta_q   <= SYNC_RESET[g];
				stable_q <= SYNC_RESET[g];
			end else begin
				meta_q   <= raw_in[g];
				stable_q <= meta_q;
			end
		end

		assign synced[g] = stable_q;
	end

	wire supply_ok  = synced[3];
	wire overload   = synced[2];
	wire ext_reset  = !synced[1];
	wire st_request = synced[0];

	// Internal readout tick
	logic tick;
	tick_divider #(
		.DIV         (seq_pkg::READOUT_DIV)
	) i_tick_divider (
		.core_clk_in (core_clk_in),
		.reset_in    (reset_in),
		.tick_out    (tick)
	);

	seq_state_t                 state_q;
	seq_state_t                 state_d;
	logic [seq_pkg::CNT_W-1:0]  start_cnt_q;
	logic [seq_pkg::CNT_W-1:0]  start_cnt_d;
	logic [seq_pkg::CNT_W-1:0]  st_cnt_q;
	logic [seq_pkg::CNT_W-1:0]  st_cnt_d;
	logic                       st_phase_q;
	logic                       st_phase_d;

	wire start_done = tick && (start_cnt_q == seq_pkg::CNT_W'(STARTUP_TICKS - 1));
	wire restart    = ext_reset || overload;
	wire st_wrap    = tick && (st_cnt_q == seq_pkg::CNT_W'(ST_HALF_TICKS - 1));
	wire st_active  = st_request && (state_q == ST_RUN);

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_OFF: begin
				if (supply_ok)
					state_d = ST_STARTUP;
			end
			ST_HOLD: begin
				if (!supply_ok)
					state_d = ST_OFF;
				else if (!restart)
					state_d = ST_STARTUP;
			end
			ST_STARTUP: begin
				if (!supply_ok)
					state_d = ST_OFF;
				else if (restart)
					state_d = ST_HOLD;
				else if (start_done)
					state_d = ST_RUN;
			end
			ST_RUN: begin
				if (!supply_ok)
					state_d = ST_OFF;
				else if (restart)
					state_d = ST_HOLD;
			end
			default: state_d = ST_OFF;
		endcase
	end

	assign start_cnt_d = (state_q != ST_STARTUP) ? '0 : (tick ? start_cnt_q + 1'b1 : start_cnt_q);
	assign st_cnt_d    = !st_active ? '0 : (st_wrap ? '0 : (tick ? st_cnt_q + 1'b1 : st_cnt_q));
	assign st_phase_d  = !st_active ? 1'b0 : (st_wrap ? !st_phase_q : st_phase_q);

	// Output codes
	wire [seq_pkg::OUT_W-1:0] st_offset = st_phase_q ? seq_pkg::ST_STEP_CODE : -seq_pkg::ST_STEP_CODE;
	wire [seq_pkg::OUT_W-1:0] live_pos  = accel_code_in + (st_active ? st_offset : '0);
	wire [seq_pkg::OUT_W-1:0] live_neg  = seq_pkg::MID_CODE - (live_pos - seq_pkg::MID_CODE);
	wire                      run_next  = (state_d == ST_RUN);
	wire                      hold_mid  = ext_reset || !run_next;
	wire                      invalid_d = !run_next || !supply_ok || ext_reset || overload;

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_q     <= ST_OFF;
			start_cnt_q <= '0;
			st_cnt_q    <= '0;
			st_phase_q  <= 1'b0;
		end else begin
			state_q     <= state_d;
			start_cnt_q <= start_cnt_d;
			st_cnt_q    <= st_cnt_d;
			st_phase_q  <= st_phase_d;
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			supply_good_out    <= 1'b0;
			output_invalid_out <= seq_pkg::FLAG_RESET_VAL;
			accel_out_pos_out  <= seq_pkg::MID_CODE;
			accel_out_neg_out  <= seq_pkg::MID_CODE;
			mid_reference_out  <= seq_pkg::MID_CODE;
		end else begin
			supply_good_out    <= supply_ok;
			output_invalid_out <= invalid_d;
			accel_out_pos_out  <= hold_mid ? seq_pkg::MID_CODE : live_pos;
			accel_out_neg_out  <= hold_mid ? seq_pkg::MID_CODE : live_neg;
			mid_reference_out  <= seq_pkg::MID_CODE;
		end
	end

	a_supply_low_off: assert property (@(posedge core_clk_in) disable iff (reset_in)
		!supply_ok |=> !supply_good_out && output_invalid_out)
		else $error("Supply low did not drop supply-good and raise flag");

	a_off_to_startup: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(state_q == ST_OFF) && supply_ok |=> state_q == ST_STARTUP)
		else $error("Startup did not begin on supply recovery");

	a_supply_good_follow: assert property (@(posedge core_clk_in) disable iff (reset_in)
		supply_ok |=> supply_good_out)
		else $error("Supply-good stayed low with supply above trip");

	a_off_waits_supply: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(state_q == ST_OFF) && !supply_ok |=> state_q == ST_OFF)
		else $error("Startup began below trip level");

	a_off_supply_low: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(state_q == ST_OFF) |-> !supply_good_out)
		else $error("Supply-good high while powered off");

	a_run_brownout: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(state_q == ST_RUN) && !supply_ok |=> state_q == ST_OFF)
		else $error("Brownout in run not taken");

	a_startup_brownout: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(state_q == ST_STARTUP) && !supply_ok |=> state_q == ST_OFF)
		else $error("Brownout in startup not taken");

	a_hold_brownout: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(state_q == ST_HOLD) && !supply_ok |=> state_q == ST_OFF)
		else $error("Brownout in hold not taken");

	a_startup_flag: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(state_q == ST_STARTUP) |-> output_invalid_out)
		else $error("Flag low during startup");

	a_off_flag_high: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(state_q == ST_OFF) |-> output_invalid_out)
		else $error("Flag low while powered off");

	a_startup_no_skip: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(state_q == ST_STARTUP) && !start_done |=> state_q != ST_RUN)
		else $error("Run entered before startup completed");

	a_startup_done_run: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(state_q == ST_STARTUP) && supply_ok && !restart && start_done |=> state_q == ST_RUN && !output_invalid_out)
		else $error("Completed startup did not clear flag");

	a_reset_pin_low: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(state_q == ST_RUN) && supply_ok && !synced[1] |=> state_q == ST_HOLD)
		else $error("Low reset level not treated as reset");

	a_reset_mid_out: assert property (@(posedge core_clk_in) disable iff (reset_in)
		ext_reset |=> accel_out_pos_out == seq_pkg::MID_CODE && accel_out_neg_out == seq_pkg::MID_CODE)
		else $error("Outputs not at mid level during reset");

	a_hold_mid_out: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(state_q == ST_HOLD) |-> accel_out_pos_out == seq_pkg::MID_CODE && accel_out_neg_out == seq_pkg::MID_CODE)
		else $error("Outputs not at mid level in hold");

	a_mid_reference: assert property (@(posedge core_clk_in) disable iff (reset_in)
		mid_reference_out == seq_pkg::MID_CODE)
		else $error("Mid reference left its level");

	a_mirror_pair: assert property (@(posedge core_clk_in) disable iff (reset_in)
		seq_pkg::OUT_W'(accel_out_pos_out + accel_out_neg_out) == '0)
		else $error("Outputs not mirrored about mid level");

	a_reset_flag_high: assert property (@(posedge core_clk_in) disable iff (reset_in)
		ext_reset |=> output_invalid_out)
		else $error("Flag low during external reset");

	a_hold_flag_high: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(state_q == ST_HOLD) |-> output_invalid_out)
		else $error("Flag low in hold");

	a_reset_keeps_hold: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(state_q == ST_HOLD) && supply_ok && ext_reset |=> state_q == ST_HOLD)
		else $error("Hold left while reset still low");

	a_selftest_level: assert property (@(posedge core_clk_in) disable iff (reset_in)
		st_active && !hold_mid |=> accel_out_pos_out != $past(accel_code_in) || $past(st_offset) == '0)
		else $error("Self-test stimulus missing");

	a_selftest_refused: assert property (@(posedge core_clk_in) disable iff (reset_in)
		!st_active |=> !st_phase_q && st_cnt_q == '0)
		else $error("Self-test wave running while not requested");

	a_run_no_stimulus: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(state_q == ST_RUN) && run_next && !st_active |=> accel_out_pos_out == $past(accel_code_in))
		else $error("Output offset without self-test request");

	a_step_toggle: assert property (@(posedge core_clk_in) disable iff (reset_in)
		st_active && st_wrap |=> st_phase_q != $past(st_phase_q))
		else $error("Self-test phase did not toggle at half period");

	a_step_size: assert property (@(posedge core_clk_in) disable iff (reset_in)
		st_active && !hold_mid |=>
		seq_pkg::OUT_W'(accel_out_pos_out - $past(accel_code_in)) == seq_pkg::ST_STEP_CODE ||
		seq_pkg::OUT_W'(accel_out_pos_out - $past(accel_code_in)) == seq_pkg::OUT_W'(12'h000 - seq_pkg::ST_STEP_CODE))
		else $error("Self-test step of wrong size");

	a_invalid_causes: assert property (@(posedge core_clk_in) disable iff (reset_in)
		overload |=> output_invalid_out)
		else $error("Flag low during overload");

	a_run_flag_low: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(state_q == ST_RUN) |-> !output_invalid_out)
		else $error("Flag high with valid outputs");

	a_overload_restart: assert property (@(posedge core_clk_in) disable iff (reset_in)
		overload && supply_ok && (state_q == ST_RUN) |=> state_q == ST_HOLD ##0 output_invalid_out)
		else $error("Overload did not restart readout");

	a_overload_holds: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(state_q == ST_HOLD) && supply_ok && overload |=> state_q == ST_HOLD)
		else $error("Hold left while overload present");

	a_start_count_bound: assert property (@(posedge core_clk_in) disable iff (reset_in)
		start_cnt_q <= seq_pkg::CNT_W'(STARTUP_TICKS))
		else $error("Startup count beyond its length");

	a_count_on_tick: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(state_q == ST_STARTUP) && !tick |=> $stable(start_cnt_q))
		else $error("Startup count moved without a readout tick");

	a_release_startup: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(state_q == ST_HOLD) && supply_ok && !restart |=> state_q == ST_STARTUP ##1 output_invalid_out)
		else $error("Reset release skipped startup");

	a_square_half: assert property (@(posedge core_clk_in) disable iff (reset_in)
		st_active && $changed(st_phase_q) |-> st_cnt_q == '0)
		else $error("Self-test phase toggled off count boundary");

	a_phase_steady: assert property (@(posedge core_clk_in) disable iff (reset_in)
		st_active && !st_wrap |=> $stable(st_phase_q))
		else $error("Self-test phase changed inside a half period");

	a_half_count_bound: assert property (@(posedge core_clk_in) disable iff (reset_in)
		st_cnt_q < seq_pkg::CNT_W'(ST_HALF_TICKS))
		else $error("Self-test count beyond half period");
endmodule

/* core/seq_pkg.sv */
// Constants for the sensor supervisory sequencer.
// Assumes a 100 MHz core clock; all timing derived here.
package seq_pkg;
	localparam int unsigned CLK_HZ          = 100000000;
	localparam int unsigned READOUT_HZ      = 200000;
	localparam int unsigned SELFTEST_HZ     = 24;
	// Readout tick divisor, longest period rounded down
	localparam int unsigned READOUT_DIV     = CLK_HZ / READOUT_HZ;
	// Readout ticks per self-test half period
	localparam int unsigned ST_HALF_TICKS   = READOUT_HZ / (2 * SELFTEST_HZ);
	// Startup sequence length in readout ticks
	localparam int unsigned STARTUP_TICKS   = 16;
	localparam int unsigned DIV_W           = 10;
	localparam int unsigned CNT_W           = 13;
	// Output code width and code levels
	localparam int unsigned OUT_W           = 12;
	localparam logic [11:0] MID_CODE        = 12'h800;
	// Offset equal to 1.3 g peak to peak: 0.65 g each way at a nominal code scale
	localparam logic [11:0] ST_STEP_CODE    = 12'h0b0;
	localparam logic        FLAG_RESET_VAL  = 1'b1;
endpackage

/* core/tick_divider.sv */
// Divides the core clock down to the internal readout tick.
// Assumes a single clock domain and asynchronous active-high reset.
module tick_divider #(
	parameter int unsigned DIV = seq_pkg::READOUT_DIV
) (
	// Clock and reset
	input  wire logic core_clk_in,
	input  wire logic reset_in,
	// Tick
	output logic      tick_out
);
	logic [seq_pkg::DIV_W-1:0] cnt_q;
	logic [seq_pkg::DIV_W-1:0] cnt_d;
	wire                       wrap = (cnt_q == seq_pkg::DIV_W'(DIV - 1));

	assign cnt_d = wrap ? '0 : cnt_q + 1'b1;

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			cnt_q    <= '0;
			tick_out <= 1'b0;
		end else begin
			cnt_q    <= cnt_d;
			tick_out <= wrap;
		end
	end

	a_tick_period: assert property (@(posedge core_clk_in) disable iff (reset_in)
		tick_out |=> !tick_out [*8])
		else $error("Readout tick repeats too soon");
endmodule

/* tb/host_board_model.sv */
// Host board model: drives the reset and self-test pins of the sequencer.
// Assumes the bench issues requests; a released pin rests at its pull level.
module host_board_model (
	// Requests from the bench
	input  wire logic reset_req_in,
	input  wire logic self_test_req_in,
	// Pins
	output logic      ext_reset_n_out,
	output logic      self_test_request_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pull-up keeps reset idle; driven low only on request
	assign ext_reset_n_out = reset_req_in ? 1'b0 : 1'b1;
	// Pull-down keeps self-test idle; raised only on request
	assign self_test_request_out = self_test_req_in ? 1'b1 : 1'b0;
endmodule

/* tb/tb_sensor_supervisory_sequencer.sv */
// Testbench for the sensor supervisory sequencer with a host board model.
// Assumes 500 clocks per readout tick; startup and half period shortened to 2 ticks.
module tb_sensor_supervisory_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 2 * 500;
	typedef struct packed {logic s, o, r; logic [11:0] c; logic g, i, k; logic [11:0] p;} row_t;
	logic        clk = 1'b0, rst = 1'b1, sup = 1'b0, ovl = 1'b0, rreq = 1'b0, streq = 1'b0;
	logic [11:0] code = 12'h123, e, v;
	logic        rst_n, st, sg, inv;
	logic [11:0] pos, neg, mid;
	int          fail_count = 0, n_checks = 0, n, h;
	row_t        rows [7] = '{
		'{1, 0, 0, 12'h123, 1, 0, 1, 12'h123},
		'{1, 1, 0, 12'h123, 1, 1, 0, 12'h000},
		'{1, 0, 0, 12'h3ff, 1, 0, 1, 12'h3ff},
		'{1, 0, 1, 12'h3ff, 1, 1, 1, 12'h800},
		'{1, 0, 0, 12'hfff, 1, 0, 1, 12'hfff},
		'{0, 0, 0, 12'hfff, 0, 1, 0, 12'h000},
		'{1, 0, 0, 12'h123, 1, 0, 1, 12'h123}};
	host_board_model i_host_board_model (.reset_req_in(rreq), .self_test_req_in(streq),
		.ext_reset_n_out(rst_n), .self_test_request_out(st));
	sensor_supervisory_sequencer #(.STARTUP_TICKS(2), .ST_HALF_TICKS(2)) i_sensor_supervisory_sequencer (
		.core_clk_in(clk), .reset_in(rst), .supply_above_trip_in(sup), .overload_in(ovl),
		.ext_reset_n_in(rst_n), .self_test_request_in(st), .accel_code_in(code),
		.supply_good_out(sg), .output_invalid_out(inv), .accel_out_pos_out(pos),
		.accel_out_neg_out(neg), .mid_reference_out(mid));
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic bound(input int k);
		if (k > 3000) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, k, 3000);
			finish_test();
		end
	endtask
	task automatic wait_inv(input logic x);
		n = 0;
		while (inv !== x) begin
			cyc(1);
			n++;
			bound(n);
		end
	endtask
	task automatic wait_chg();
		v = pos;
		h = 0;
		while (pos === v) begin
			cyc(1);
			h++;
			bound(h);
		end
	endtask
	task automatic reset_chk();
		rst = 1'b1;
		cyc(10);
		chk({11'h0, sg}, 12'h000);
		chk({11'h0, inv}, 12'h001);
		chk(pos, 12'h800);
		chk(neg, 12'h800);
		chk(mid, 12'h800);
		rst = 1'b0;
		cyc(2);
		chk({11'h0, sg}, 12'h000);
		chk({11'h0, inv}, 12'h001);
		$display("reset test done");
	endtask
	initial begin
		reset_chk();
		foreach (rows[j]) begin
			{sup, ovl, rreq, code} = {rows[j].s, rows[j].o, rows[j].r, rows[j].c};
			wait_inv(rows[j].i);
			cyc(4);
			chk({11'h0, sg}, {11'h0, rows[j].g});
			chk({11'h0, inv}, {11'h0, rows[j].i});
			if (rows[j].k) begin
				chk(pos, rows[j].p);
				chk(neg, 12'h000 - rows[j].p);
			end
		end
		$display("row test done");
		streq = 1'b1;
		wait_chg();
		wait_chg();
		wait_chg();
		chk(12'(h), 12'(HALF));
		e = 12'h123 - seq_pkg::ST_STEP_CODE;
		chk(pos, e);
		chk(neg, 12'h000 - e);
		wait_chg();
		chk(12'(h), 12'(HALF));
		chk(pos, 12'h123 + seq_pkg::ST_STEP_CODE);
		$display("self-test done");
		rreq = 1'b1;
		wait_inv(1'b1);
		cyc(2 * HALF);
		chk(pos, 12'h800);
		chk({11'h0, inv}, 12'h001);
		rreq = 1'b0;
		$display("self-test in reset done");
		wait_inv(1'b0);
		reset_chk();
		streq = 1'b0;
		wait_inv(1'b0);
		cyc(4);
		chk(pos, 12'h123);
		chk({11'h0, inv}, 12'h000);
		$display("reset recovery done");
		finish_test();
	end
endmodule
